// ==== bench/core_side_model.sv ====
// Purpose: data memory and return stack facing the decoder
// Assumes: read data is due one clock after the read strobe
// Notes: between reads the data lines toggle so stale bytes never pass
`timescale 1ns/1ns
module core_side_model (
  input wire logic i_core_clk,
  input wire logic [11:0] i_mem_addr,
  input wire logic i_mem_re,
  input wire logic i_mem_we,
  input wire logic [7:0] i_mem_wdata,
  output logic [7:0] o_mem_rdata,
  input wire logic i_push,
  input wire logic [20:0] i_push_addr,
  input wire logic i_pop,
  output logic [20:0] o_head
);
  logic [7:0] mem [0:4095];
  logic [20:0] stk [0:7];
  logic [2:0] sp = 3'h0;
  initial o_mem_rdata = 8'h00;
  // memory port and eight-deep stack
  always @(posedge i_core_clk) begin
    o_mem_rdata <= i_mem_re ? mem[i_mem_addr] : ~o_mem_rdata;
    if (i_mem_we)
      mem[i_mem_addr] <= i_mem_wdata;
    if (i_push) begin
      stk[sp + 3'h1] <= i_push_addr;
      sp <= sp + 3'h1;
    end else if (i_pop)
      sp <= sp - 3'h1;
  end
  assign o_head = stk[sp];
endmodule

// ==== bench/test_xor_and_extended_op_decode.sv ====
// Purpose: self-checking bench for the xor and extended opcode decoder
// Assumes: one instruction and one bus access in flight at a time
// Notes: random operands from a fixed seed plus boundary cases
`timescale 1ns/1ns
`include "xor_ext_map.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("FAIL %0t got %h want %h", $time, g, e); end end
module test_xor_and_extended_op_decode;
  logic i_core_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_instr_valid = 1'b0;
  logic [15:0] i_instr = 16'h0000;
  logic [20:0] i_pc = 21'h000000;
  logic [7:0] i_s_awaddr = 8'h00, i_s_araddr = 8'h00;
  logic [31:0] i_s_wdata = 32'h0;
  logic [3:0] i_s_wstrb = 4'h3;
  logic i_s_awvalid = 0, i_s_wvalid = 0, i_s_bready = 0, i_s_arvalid = 0, i_s_rready = 0;
  wire o_instr_ready, o_not_handled, o_mem_re, o_mem_we, o_stack_push, o_stack_pop, o_pc_load;
  wire o_s_awready, o_s_wready, o_s_bvalid, o_s_arready, o_s_rvalid;
  wire [1:0] o_s_bresp, o_s_rresp;
  wire [31:0] o_s_rdata;
  wire [11:0] o_mem_addr;
  wire [7:0] o_mem_wdata, i_mem_rdata;
  wire [20:0] o_stack_push_addr, i_stack_head, o_pc_value;
  int err_total = 0, checks = 0, cyc = 0;
  logic nh_seen = 1'b0;
  logic [20:0] pc_seen = 21'h0;
  logic [1:0] br, rr;
  logic [15:0] ext_ops [8] = '{16'he805, 16'he8c5, 16'h0014, 16'heb05, 16'heb85,
    16'hea05, 16'he905, 16'he9c5};
  xor_and_extended_op_decode u_xor_and_extended_op_decode (.i_core_clk, .i_reset_n,
    .i_instr_valid, .i_instr, .i_pc, .o_instr_ready, .o_not_handled, .o_mem_addr, .o_mem_re,
    .o_mem_we, .o_mem_wdata, .i_mem_rdata, .o_stack_push, .o_stack_push_addr, .o_stack_pop,
    .i_stack_head, .o_pc_load, .o_pc_value, .i_s_awaddr, .i_s_awvalid, .o_s_awready,
    .i_s_wdata, .i_s_wstrb, .i_s_wvalid, .o_s_wready, .o_s_bresp, .o_s_bvalid, .i_s_bready,
    .i_s_araddr, .i_s_arvalid, .o_s_arready, .o_s_rdata, .o_s_rresp, .o_s_rvalid, .i_s_rready);
  core_side_model u_model (.i_core_clk, .i_mem_addr(o_mem_addr), .i_mem_re(o_mem_re),
    .i_mem_we(o_mem_we), .i_mem_wdata(o_mem_wdata), .o_mem_rdata(i_mem_rdata),
    .i_push(o_stack_push), .i_push_addr(o_stack_push_addr), .i_pop(o_stack_pop),
    .o_head(i_stack_head));
  initial forever #20 i_core_clk = ~i_core_clk;
  task automatic stop_test;
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // catch pulses and cut a hang short
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (o_not_handled)
      nh_seen <= 1'b1;
    if (o_pc_load)
      pc_seen <= o_pc_value;
    if (cyc == 30000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_s_awaddr <= a;
    i_s_wdata <= d;
    i_s_awvalid <= 1'b1;
    i_s_wvalid <= 1'b1;
    i_s_bready <= 1'b1;
    fork
      begin
        do @(posedge i_core_clk); while (!o_s_awready);
        i_s_awvalid <= 1'b0;
      end
      begin
        do @(posedge i_core_clk); while (!o_s_wready);
        i_s_wvalid <= 1'b0;
      end
    join
    do @(posedge i_core_clk); while (!o_s_bvalid);
    br = o_s_bresp;
    i_s_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    i_s_araddr <= a;
    i_s_arvalid <= 1'b1;
    i_s_rready <= 1'b1;
    do @(posedge i_core_clk); while (!o_s_arready);
    i_s_arvalid <= 1'b0;
    do @(posedge i_core_clk); while (!o_s_rvalid);
    d = o_s_rdata;
    rr = o_s_rresp;
    i_s_rready <= 1'b0;
  endtask
  // offer one word, then wait until the decoder is ready again
  task automatic op(input logic [15:0] w);
    @(posedge i_core_clk);
    i_instr <= w;
    i_pc <= i_pc + 21'h2;
    i_instr_valid <= 1'b1;
    do @(posedge i_core_clk); while (!o_instr_ready);
    i_instr_valid <= 1'b0;
    i_instr <= ~w;
    repeat (2) @(posedge i_core_clk);
    while (!o_instr_ready) @(posedge i_core_clk);
    @(posedge i_core_clk);
  endtask
  function automatic logic [11:0] addr_of(input logic [7:0] f, input logic a, x,
      input logic [3:0] bk, input logic [11:0] p);
    if (a)
      return {bk, f};
    if (x && f <= 8'h5f)
      return p + 12'(f);
    return {f[7] ? 4'hf : 4'h0, f};
  endfunction
  task automatic xloop(input logic x);
    logic [7:0] f, acc, v, res;
    logic [3:0] bk;
    logic [11:0] p, ad;
    logic [31:0] r;
    logic d, a;
    for (int i = 0; i < 10; i++) begin
      f = x ? 8'($urandom % 128) : 8'($urandom);
      {acc, v, bk, p, d, a} = 34'({$urandom, $urandom});
      if (i < 2) begin
        f = 8'h5f + 8'(i);
        a = 1'b0;
      end
      ad = addr_of(f, a, x, bk, p);
      wr(`REG_ACC, 32'(acc));
      wr(`REG_BANK, 32'(bk));
      wr(`REG_PTR2, 32'(p));
      u_model.mem[ad] = v;
      res = acc ^ v;
      op({6'h06, d, a, f});
      `CHK(u_model.mem[ad], d ? res : v)
      rd(`REG_ACC, r);
      `CHK(r[7:0], d ? acc : res)
      rd(`REG_STAT, r);
      `CHK(r[1:0], {res[7], res == 8'h00})
    end
  endtask
  initial begin
    logic [31:0] r, s0;
    logic [11:0] p, src, dst;
    logic [7:0] acc, k8, v, ra;
    logic [12:0] lt;
    logic [6:0] z, zd;
    logic [5:0] k;
    logic [1:0] sel;
    logic [20:0] ret;
    void'($urandom(66688));
    repeat (8) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    rd(`REG_CTRL, r);
    `CHK(r, 32'h0)
    `CHK(rr, `RESP_OKAY)
    rd(8'h20, r);
    `CHK(rr, `RESP_SLVERR)
    wr(`REG_STAT, 32'h3);
    `CHK(br, `RESP_SLVERR)
    // a write on the upper lane only must leave the 8-bit accumulator alone
    i_s_wstrb <= 4'h2;
    wr(`REG_ACC, 32'h5a);
    i_s_wstrb <= 4'h3;
    rd(`REG_ACC, r);
    `CHK(r[7:0], 8'h00)
    foreach (ext_ops[i]) begin
      nh_seen = 1'b0;
      op(ext_ops[i]);
      `CHK(nh_seen, 1'b1)
    end
    xloop(1'b0);
    wr(`REG_CTRL, 32'h1);
    `CHK(br, `RESP_OKAY)
    xloop(1'b1);
    rd(`REG_STAT, s0);
    for (int i = 0; i < 8; i++) begin
      sel = i[1:0];
      {p, k, lt, acc} = 39'({$urandom, $urandom});
      ra = `REG_PTR0 + {4'h0, (sel == 2'h3) ? 2'h2 : sel, 2'h0};
      wr(ra, 32'(p));
      if (sel == 2'h3) begin
        wr(`REG_LATCH, 32'(lt));
        wr(`REG_ACC, 32'(acc));
        op(`OP_CALL_VIA_ACCUMULATOR);
        `CHK(pc_seen, {lt[12:8], lt[7:0], acc})
        ret = i_pc + 21'h2;
      end
      op({i < 4 ? `OP_PTR_ADD : `OP_PTR_SUB, sel, k});
      rd(ra, r);
      `CHK(r[11:0], i < 4 ? p + 12'(k) : p - 12'(k))
      if (sel == 2'h3)
        `CHK(pc_seen, ret)
    end
    for (int i = 0; i < 3; i++) begin
      {p, k8} = 20'($urandom);
      if (i == 0)
        p = 12'h000;
      wr(`REG_PTR2, 32'(p));
      op({`OP_LIT_PUSH, k8});
      `CHK(u_model.mem[p], k8)
      rd(`REG_PTR2, r);
      `CHK(r[11:0], p - 12'h1)
    end
    for (int b = 0; b < 2; b++) begin
      {p, z, v} = 27'($urandom);
      zd = z ^ 7'h40;
      src = p + 12'(z);
      dst = b ? p + 12'(zd) : src ^ 12'h800;
      wr(`REG_PTR2, 32'(p));
      u_model.mem[src] = v;
      op({`OP_MOVE, b[0], z});
      op(b ? {9'h1e0, zd} : {`OP_WORD2_PFX, dst});
      `CHK(u_model.mem[dst], v)
    end
    rd(`REG_STAT, r);
    `CHK(r[1:0], s0[1:0])
    stop_test();
  end
endmodule

// ==== bench/xor_ext_sva.sv ====
// Purpose: port checks of the xor and extended opcode decoder
// Assumes: a word is taken at edge 0 and effects are counted in edges after it
// Notes: bound to the decoder top module
`timescale 1ns/1ns
module xor_ext_sva (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_instr_valid,
  input wire logic [15:0] i_instr,
  input wire logic [20:0] i_pc,
  input wire logic o_instr_ready,
  input wire logic o_not_handled,
  input wire logic o_mem_re,
  input wire logic o_mem_we,
  input wire logic o_stack_push,
  input wire logic [20:0] o_stack_push_addr,
  input wire logic o_stack_pop,
  input wire logic [20:0] i_stack_head,
  input wire logic o_pc_load,
  input wire logic [20:0] o_pc_value
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  // an xor word being taken, and the three idle edges before the next word
  sequence take_xor;
    i_instr_valid && o_instr_ready && i_instr[15:10] == 6'h06;
  endsequence
  sequence back_in_4;
    !o_instr_ready[*3] ##1 o_instr_ready;
  endsequence
  xor_read_a: assert property (take_xor |=> o_mem_re)
    else $error("xor word did not read its operand");
  xor_cycle_a: assert property (take_xor |=> back_in_4)
    else $error("xor did not finish in one instruction cycle");
  re_pulse_a: assert property (o_mem_re |=> !o_mem_re)
    else $error("memory read strobe longer than one clock");
  xor_acc_dest_a: assert property (take_xor ##0 !i_instr[9] |=> !o_mem_we[*4])
    else $error("xor to accumulator wrote memory");
  xor_file_dest_a: assert property (take_xor ##0 i_instr[9] |-> ##4 o_mem_we)
    else $error("xor to file did not write back");
  ret_pc_a: assert property (o_stack_pop |-> o_pc_load && o_pc_value == $past(i_stack_head))
    else $error("return did not load stack head");
  ret_wait_a: assert property (o_stack_pop |=> back_in_4)
    else $error("return did not take two cycles");
  call_push_a: assert property (o_stack_push |->
    o_stack_push_addr == $past(i_pc, 3) + 21'h2 ##1 o_pc_load)
    else $error("call pushed wrong address or did not jump");
  refused_a: assert property (o_not_handled |-> o_instr_ready && !o_mem_we && !o_pc_load)
    else $error("refused word had an effect");
endmodule
bind xor_and_extended_op_decode xor_ext_sva u_xor_ext_sva (.i_core_clk, .i_reset_n,
  .i_instr_valid, .i_instr, .i_pc, .o_instr_ready, .o_not_handled, .o_mem_re, .o_mem_we,
  .o_stack_push, .o_stack_push_addr, .o_stack_pop, .i_stack_head, .o_pc_load, .o_pc_value);

// ==== logic/file_addr_resolve.v ====
// Purpose: turns the 8-bit file field and access bit into a 12-bit data address
// Assumes: bank select register low nibble picks one of 16 banks of 256 bytes
// Notes: purely combinational, evaluated on the opcode being accepted
`timescale 1ns/1ns
`include "xor_ext_map.vh"
module file_addr_resolve (
  input wire [7:0] i_file,
  input wire i_access,
  input wire [7:0] i_bank,
  input wire i_ext_en,
  input wire [11:0] i_ptr_two,
  output reg [11:0] o_addr,
  output reg o_indexed
);
  // bank, indexed offset or access bank
  always @* begin
    o_indexed = 1'b0;
    if (i_access) begin
      o_addr = {i_bank[3:0], i_file};
    end else if (i_ext_en && (i_file <= `ILO_LIMIT)) begin
      o_addr = i_ptr_two + {4'h0, i_file};
      o_indexed = 1'b1;
    end else if (i_file < `ACCESS_SPLIT) begin
      o_addr = {`ACCESS_LO_PAGE, i_file};
    end else begin
      o_addr = {`ACCESS_HI_PAGE, i_file};
    end
  end
endmodule

// ==== logic/xor_and_extended_op_decode.v ====
// Purpose: executes xor-with-file and the extended opcode group of the core
// Assumes: data memory answers a read one clock after o_mem_re; fetch on same clock
// Notes: one instruction cycle is four clocks (q1..q4); registers on axi4-lite
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`include "xor_ext_map.vh"
module xor_and_extended_op_decode (
  input wire i_core_clk,
  input wire i_reset_n,
  input wire i_instr_valid,
  input wire [15:0] i_instr,
  input wire [20:0] i_pc,
  output reg o_instr_ready,
  output reg o_not_handled,
  output reg [11:0] o_mem_addr,
  output reg o_mem_re,
  output reg o_mem_we,
  output reg [7:0] o_mem_wdata,
  input wire [7:0] i_mem_rdata,
  output reg o_stack_push,
  output reg [20:0] o_stack_push_addr,
  output reg o_stack_pop,
  input wire [20:0] i_stack_head,
  output reg o_pc_load,
  output reg [20:0] o_pc_value,
  input wire [7:0] i_s_awaddr,
  input wire i_s_awvalid,
  output reg o_s_awready,
  input wire [31:0] i_s_wdata,
  input wire [3:0] i_s_wstrb,
  input wire i_s_wvalid,
  output reg o_s_wready,
  output reg [1:0] o_s_bresp,
  output reg o_s_bvalid,
  input wire i_s_bready,
  input wire [7:0] i_s_araddr,
  input wire i_s_arvalid,
  output reg o_s_arready,
  output reg [31:0] o_s_rdata,
  output reg [1:0] o_s_rresp,
  output reg o_s_rvalid,
  input wire i_s_rready
);
  localparam S_IDLE = 3'd0;
  localparam S_RD = 3'd1;
  localparam S_PROC = 3'd2;
  localparam S_WR = 3'd3;
  localparam S_NOP = 3'd4;
  localparam S_WORD2 = 3'd5;
  localparam OP_XOR = 3'd0;
  localparam OP_ADD = 3'd1;
  localparam OP_SUB = 3'd2;
  localparam OP_PUSH = 3'd3;
  localparam OP_MOVE = 3'd4;
  localparam OP_CALL = 3'd5;

  reg rst_meta_q;
  reg rst_sync_q;
  reg [2:0] state_q;
  reg [2:0] op_q;
  reg [15:0] instr_q;
  reg [1:0] nop_q;
  reg [7:0] result_q;
  reg [7:0] acc_q;
  reg [7:0] bank_q;
  reg ext_en_q;
  reg flag_z_q;
  reg flag_n_q;
  reg [11:0] ptr0_q;
  reg [11:0] ptr1_q;
  reg [11:0] ptr2_q;
  reg [7:0] pch_q;
  reg [4:0] pcu_q;
  reg [20:0] next_pc_q;
  reg [7:0] awaddr_q;
  reg aw_got_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_got_q;
  reg [31:0] rd_data;
  reg rd_ok;
  reg wr_ok;
  reg [11:0] ptr_new;
  reg [15:0] wr_old;
  wire rst_n;
  wire [11:0] res_addr;
  wire is_xor;
  wire [7:0] hi;
  wire wr_fire;
  wire [11:0] sel_ptr;
  wire [11:0] lit6;
  wire [15:0] wr_new;

  // merge a bus write into a register honouring byte strobes
  function [15:0] wmerge;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      wmerge = old;
      if (strb[0]) wmerge[7:0] = data[7:0];
      if (strb[1]) wmerge[15:8] = data[15:8];
    end
  endfunction

  // pick one of the three pointers by the 2-bit field
  function [11:0] ptr_pick;
    input [1:0] sel;
    input [11:0] p0;
    input [11:0] p1;
    input [11:0] p2;
    begin
      case (sel)
        2'd0: ptr_pick = p0;
        2'd1: ptr_pick = p1;
        default: ptr_pick = p2; // select 3 works on pointer two
      endcase
    end
  endfunction

  // reset release through two flops
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_sync_q;

  // opcode classification of the word on offer
  assign hi = i_instr[15:8];
  assign is_xor = (i_instr[15:10] == `OP_XOR_PFX);
  assign sel_ptr = ptr_pick(instr_q[7:6], ptr0_q, ptr1_q, ptr2_q);
  assign lit6 = {6'h00, instr_q[5:0]};
  assign wr_fire = aw_got_q & w_got_q & ~o_s_bvalid;
  // strobe-merged value of the register being written, cut per target below
  assign wr_new = wmerge(wr_old, wdata_q, wstrb_q);

  file_addr_resolve u_resolve (
    .i_file(i_instr[7:0]),
    .i_access(i_instr[8]),
    .i_bank(bank_q),
    .i_ext_en(ext_en_q),
    .i_ptr_two(ptr2_q),
    .o_addr(res_addr),
    .o_indexed()
  );

  // pointer arithmetic for the add and subtract forms
  always @* begin
    if (op_q == OP_ADD) begin
      ptr_new = sel_ptr + lit6;
    end else begin
      ptr_new = sel_ptr - lit6;
    end
  end

  // register read mux
  always @* begin
    rd_data = 32'h00000000;
    rd_ok = 1'b1;
    case (i_s_araddr)
      `REG_CTRL: rd_data[`CTRL_EXT_BIT] = ext_en_q;
      `REG_BANK: rd_data[7:0] = bank_q;
      `REG_ACC: rd_data[7:0] = acc_q;
      `REG_STAT: begin
        rd_data[`STAT_Z_BIT] = flag_z_q;
        rd_data[`STAT_N_BIT] = flag_n_q;
        rd_data[`STAT_BUSY_BIT] = (state_q != S_IDLE);
      end
      `REG_PTR0: rd_data[11:0] = ptr0_q;
      `REG_PTR1: rd_data[11:0] = ptr1_q;
      `REG_PTR2: rd_data[11:0] = ptr2_q;
      `REG_LATCH: rd_data[12:0] = {pcu_q, pch_q};
      default: rd_ok = 1'b0;
    endcase
  end

  // write address decode
  always @* begin
    case (awaddr_q)
      `REG_CTRL, `REG_BANK, `REG_ACC, `REG_PTR0, `REG_PTR1, `REG_PTR2,
      `REG_LATCH: wr_ok = 1'b1;
      default: wr_ok = 1'b0; // status is read-only
    endcase
    case (awaddr_q)
      `REG_BANK: wr_old = {8'h00, bank_q};
      `REG_ACC: wr_old = {8'h00, acc_q};
      `REG_PTR0: wr_old = {4'h0, ptr0_q};
      `REG_PTR1: wr_old = {4'h0, ptr1_q};
      `REG_PTR2: wr_old = {4'h0, ptr2_q};
      default: wr_old = 16'h0000;
    endcase
  end

  // axi4-lite handshakes
  always @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_s_awready <= 1'b1;
      o_s_wready <= 1'b1;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      o_s_bvalid <= 1'b0;
      o_s_bresp <= `RESP_OKAY;
      o_s_arready <= 1'b1;
      o_s_rvalid <= 1'b0;
      o_s_rdata <= 32'h00000000;
      o_s_rresp <= `RESP_OKAY;
    end else begin
      if (i_s_awvalid && o_s_awready) begin
        awaddr_q <= i_s_awaddr;
        aw_got_q <= 1'b1;
        o_s_awready <= 1'b0;
      end
      if (i_s_wvalid && o_s_wready) begin
        wdata_q <= i_s_wdata;
        wstrb_q <= i_s_wstrb;
        w_got_q <= 1'b1;
        o_s_wready <= 1'b0;
      end
      if (wr_fire) begin
        o_s_bvalid <= 1'b1;
        o_s_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (o_s_bvalid && i_s_bready) begin
        o_s_bvalid <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        o_s_awready <= 1'b1;
        o_s_wready <= 1'b1;
      end
      if (i_s_arvalid && o_s_arready) begin
        o_s_rdata <= rd_data;
        o_s_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        o_s_rvalid <= 1'b1;
        o_s_arready <= 1'b0;
      end
      if (o_s_rvalid && i_s_rready) begin
        o_s_rvalid <= 1'b0;
        o_s_arready <= 1'b1;
      end
    end
  end

  // instruction sequencer; core updates override a same-cycle bus write
  always @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      op_q <= OP_XOR;
      instr_q <= 16'h0000;
      nop_q <= 2'h0;
      result_q <= `RST_BYTE;
      acc_q <= `RST_BYTE;
      bank_q <= `RST_BYTE;
      ext_en_q <= 1'b0;
      flag_z_q <= 1'b0;
      flag_n_q <= 1'b0;
      ptr0_q <= `RST_PTR;
      ptr1_q <= `RST_PTR;
      ptr2_q <= `RST_PTR;
      pch_q <= `RST_BYTE;
      pcu_q <= `RST_UPPER;
      next_pc_q <= 21'h000000;
      o_instr_ready <= 1'b1;
      o_not_handled <= 1'b0;
      o_mem_addr <= `RST_PTR;
      o_mem_re <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_wdata <= `RST_BYTE;
      o_stack_push <= 1'b0;
      o_stack_push_addr <= 21'h000000;
      o_stack_pop <= 1'b0;
      o_pc_load <= 1'b0;
      o_pc_value <= 21'h000000;
    end else begin
      o_mem_re <= 1'b0;
      o_mem_we <= 1'b0;
      o_stack_push <= 1'b0;
      o_stack_pop <= 1'b0;
      o_pc_load <= 1'b0;
      o_not_handled <= 1'b0;
      if (wr_fire && wr_ok) begin
        case (awaddr_q)
          `REG_CTRL: ext_en_q <= wstrb_q[0] ? wdata_q[`CTRL_EXT_BIT] : ext_en_q;
          `REG_BANK: bank_q <= wr_new[7:0];
          `REG_ACC: acc_q <= wr_new[7:0];
          `REG_PTR0: ptr0_q <= wr_new[11:0];
          `REG_PTR1: ptr1_q <= wr_new[11:0];
          `REG_PTR2: ptr2_q <= wr_new[11:0];
          default: begin
            pch_q <= wstrb_q[0] ? wdata_q[7:0] : pch_q;
            pcu_q <= wstrb_q[1] ? wdata_q[`LATCH_UPPER_LSB +: 5] : pcu_q;
          end
        endcase
      end
      case (state_q)
        S_IDLE: begin
          if (i_instr_valid) begin
            instr_q <= i_instr;
            next_pc_q <= i_pc + `PC_STEP;
            o_instr_ready <= 1'b0;
            state_q <= S_RD;
            if (is_xor) begin
              // q1 decode, address for the q2 read
              op_q <= OP_XOR;
              o_mem_addr <= res_addr;
              o_mem_re <= 1'b1;
            end else if (ext_en_q && hi == `OP_PTR_ADD) begin
              op_q <= OP_ADD;
            end else if (ext_en_q && hi == `OP_PTR_SUB) begin
              op_q <= OP_SUB;
            end else if (ext_en_q && hi == `OP_LIT_PUSH) begin
              op_q <= OP_PUSH;
            end else if (ext_en_q && hi == `OP_MOVE) begin
              // source is pointer two plus 7-bit offset
              op_q <= OP_MOVE;
              o_mem_addr <= ptr2_q + {5'h00, i_instr[6:0]};
              o_mem_re <= 1'b1;
            end else if (ext_en_q && i_instr == `OP_CALL_VIA_ACCUMULATOR) begin
              op_q <= OP_CALL;
            end else begin
              o_not_handled <= 1'b1;
              o_instr_ready <= 1'b1;
              state_q <= S_IDLE;
            end
          end
        end
        S_RD: state_q <= S_PROC;
        S_PROC: begin
          state_q <= S_WR;
          if (op_q == OP_XOR) begin
            result_q <= acc_q ^ i_mem_rdata;
          end else if (op_q == OP_MOVE) begin
            result_q <= i_mem_rdata;
          end else if (op_q == OP_CALL) begin
            o_stack_push <= 1'b1;
            o_stack_push_addr <= next_pc_q;
          end
        end
        S_WR: begin
          state_q <= S_IDLE;
          o_instr_ready <= 1'b1;
          nop_q <= 2'h0;
          case (op_q)
            OP_XOR: begin
              if (instr_q[9]) begin
                o_mem_we <= 1'b1;
                o_mem_wdata <= result_q;
              end else begin
                acc_q <= result_q;
              end
              flag_z_q <= (result_q == 8'h00);
              flag_n_q <= result_q[7];
            end
            OP_ADD, OP_SUB: begin
              case (instr_q[7:6])
                2'd0: ptr0_q <= ptr_new;
                2'd1: ptr1_q <= ptr_new;
                default: ptr2_q <= ptr_new;
              endcase
              if (instr_q[7:6] == `SEL_PTR_TWO_RET) begin
                o_stack_pop <= 1'b1;
                o_pc_load <= 1'b1;
                o_pc_value <= i_stack_head;
                o_instr_ready <= 1'b0;
                state_q <= S_NOP;
              end
            end
            OP_PUSH: begin
              o_mem_addr <= ptr2_q;
              o_mem_we <= 1'b1;
              o_mem_wdata <= instr_q[7:0];
              ptr2_q <= ptr2_q - 12'h001;
            end
            OP_CALL: begin
              o_pc_load <= 1'b1;
              o_pc_value <= {pcu_q, pch_q, acc_q};
              o_instr_ready <= 1'b0;
              state_q <= S_NOP;
            end
            default: state_q <= S_WORD2; // move waits for its second word
          endcase
        end
        S_WORD2: begin
          if (i_instr_valid) begin
            // bit 7 picks indexed or absolute destination
            o_instr_ready <= 1'b0;
            o_mem_addr <= instr_q[7] ? (ptr2_q + {5'h00, i_instr[6:0]}) : i_instr[11:0];
            o_mem_we <= 1'b1;
            o_mem_wdata <= result_q;
            nop_q <= 2'h1;
            state_q <= S_NOP;
          end
        end
        S_NOP: begin
          nop_q <= nop_q + 2'h1;
          if (nop_q == `Q_LAST) begin
            state_q <= S_IDLE;
            o_instr_ready <= 1'b1;
          end
        end
        default: begin
          state_q <= S_IDLE;
          o_instr_ready <= 1'b1;
        end
      endcase
    end
  end
endmodule

// ==== logic/xor_ext_map.vh ====
// Purpose: constants for the xor-with-file and extended opcode decoder
// Assumes: 32-bit axi4-lite register bus, 8-bit data path, 12-bit data address
// Notes: included by the decoder and the file address resolver
// Behaviour
// - Opcode 0001 10da ffff ffff is xor of accumulator with file register f.
// - Destination bit 0 writes accumulator, 1 writes file register back.
// - Access bit 0 uses access bank, 1 uses bank select register bank.
// - Access 0, extension on, f at most 95: indexed literal offset addressing.
// - Xor-with-file changes only negative and zero flags.
// - Extension and indexed mode are off after reset until enable bit set.
// - Enabled extension adds eight opcodes; none of them changes any flag.
// - 1110 1001 ffkk kkkk subtracts 6-bit literal from chosen pointer, one cycle.
// - Add form with select 11 adds to pointer two then returns, two cycles.
// - Subtract form with select 11 subtracts from pointer two then returns.
// - 1110 1010 kkkk kkkk stores literal at pointer two, decrements it.
// - Opcode 0000 0000 0001 0100 is a two-cycle call through accumulator.
// - Two-word moves: 1110 1011 then 1111 prefix; bit 7 picks destination kind.
// - Add/subtract-return load pc from stack head, second cycle is no-op.
// - Call pushes next address, pc low from accumulator, upper from latches.
`ifndef XOR_EXT_MAP_VH
`define XOR_EXT_MAP_VH
// register byte offsets
`define REG_CTRL 8'h00
`define REG_BANK 8'h04
`define REG_ACC 8'h08
`define REG_STAT 8'h0c
`define REG_PTR0 8'h10
`define REG_PTR1 8'h14
`define REG_PTR2 8'h18
`define REG_LATCH 8'h1c
// field positions
`define CTRL_EXT_BIT 0
`define STAT_Z_BIT 0
`define STAT_N_BIT 1
`define STAT_BUSY_BIT 2
`define LATCH_UPPER_LSB 8
// reset values
`define RST_BYTE 8'h00
`define RST_PTR 12'h000
`define RST_UPPER 5'h00
// opcode patterns
`define OP_XOR_PFX 6'h06
`define OP_PTR_ADD 8'he8
`define OP_PTR_SUB 8'he9
`define OP_LIT_PUSH 8'hea
`define OP_MOVE 8'heb
`define OP_CALL_VIA_ACCUMULATOR 16'h0014
`define OP_WORD2_PFX 4'hf
`define SEL_PTR_TWO_RET 2'h3
// addressing
`define ILO_LIMIT 8'h5f
`define ACCESS_SPLIT 8'h80
`define ACCESS_HI_PAGE 4'hf
`define ACCESS_LO_PAGE 4'h0
// timing: clocks per instruction cycle minus one, pc step of one word
`define Q_LAST 2'h3
`define PC_STEP 21'h000002
// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif
